// file: pkg/alc_volume_defs.vh
// Constants shared by the input volume and level-control stage
// How it works
// - While level control runs, the applied gain is copied to the current-gain output.
// - Current gain reads back valid only in three-wire serial control mode.
// - Gain codes step 0.375 dB: F1H +36 dB, 91H 0 dB, 01H -54 dB, 00H mute.
// - After both enables clear, output is zero until manual volume starts.
// - Level control off and filter select 1 gives manual volume from gain fields.
// - Manual gain applies at a zero crossing or when the timeout expires.
// - Link bit 1: left field drives both channels; 0: separate fields.
// - Each channel runs its own zero-crossing detection and timeout.
// - Gains written while filter is powered down are held and used at power-up.
// - Writing a different gain restarts that channel's timeout counter.
// - Writing the same gain again does not restart the counter.
// - Limiter zero-cross select 0 waits for crossings unless fast limit is on; select 1 steps at once.
// - Recovery never raises gain above the gain ceiling.
// - Timeout selection 00..11 gives 128, 256, 512, 1024 sample periods.
// - After each wait period gain rises by the recovery step of 1..4 codes.
// - Fast recovery runs 4, 8 or 16 times faster for codes 00, 01, 10.
`ifndef ALC_VOLUME_DEFS_VH
`define ALC_VOLUME_DEFS_VH

// Gain code reset, mute and minimum values
`define IN_GAIN_RESET 8'hE1
`define GAIN_MUTE 8'h00
`define GAIN_MIN 8'h01
// Base periods in samples
`define ZC_BASE_SAMPLES 11'h080
`define WAIT_BASE_SAMPLES 15'h0080
// Limiter detection and reset levels on 24-bit magnitude
`define LVL_M2P5 24'h5F_FDAC
`define LVL_M4P1 24'h4F_D580
`define LVL_M6P0 24'h40_26A8
`define LVL_M8P5 24'h30_1AD8
`define LVL_M12 24'h20_2678
// Selector reset values
`define ZC_SEL_RESET 2'h0
`define FAST_SEL_RESET 2'h0

`endif

// file: verilog/sample_fifo.v
// Small valid/ready FIFO for stereo sample words
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Fill side
  input wire wr_valid_i,
  input wire [WIDTH-1:0] wr_data_i,
  output wire wr_ready_o,
  // Drain side
  output wire rd_valid_o,
  output wire [WIDTH-1:0] rd_data_o,
  input wire rd_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = wr_valid_i && wr_ready_o;
  wire pop = rd_valid_o && rd_ready_i;

  // Honest full and empty
  assign wr_ready_o = (count != DEPTH[AW:0]);
  assign rd_valid_o = (count != {(AW+1){1'b0}});
  assign rd_data_o = mem[rd_ptr];

  // Pointer and occupancy update
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= wr_data_i;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// file: verilog/gain_channel.v
// One channel of zero-crossing gain update and gain scaling
`timescale 1ns/1ps
`include "alc_volume_defs.vh"
module gain_channel #(
  parameter DW = 24
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Sample step
  input wire run_i,
  input wire step_i,
  input wire signed [DW-1:0] sample_i,
  // Gain request
  input wire wr_i,
  input wire [7:0] wr_gain_i,
  input wire force_i,
  input wire [1:0] zc_sel_i,
  // Result
  output wire signed [DW-1:0] scaled_o,
  output reg [7:0] gain_o
);
  reg [7:0] last_wr;
  reg [7:0] pending;
  reg busy;
  reg [10:0] cnt;
  reg prev_sign;
  wire zc = (sample_i[DW-1] != prev_sign) || (sample_i == {DW{1'b0}});
  wire [10:0] tmo = (`ZC_BASE_SAMPLES << zc_sel_i) - 11'h001;

  // Linear gain: 16 codes per 6 dB octave, fraction table in Q2.14
  function [DW-1:0] scale;
    input [DW-1:0] smp;
    input [7:0] code;
    reg [7:0] d;
    reg [15:0] f;
    reg signed [63:0] p;
    reg signed [63:0] lim;
    begin
      d = code - 8'h01;
      lim = 64'sd1 <<< (DW - 1);
      case (d[3:0])
        4'h0: f = 16'h4000;
        4'h1: f = 16'h42D3;
        4'h2: f = 16'h45C6;
        4'h3: f = 16'h48D9;
        4'h4: f = 16'h4C10;
        4'h5: f = 16'h4F6B;
        4'h6: f = 16'h52EC;
        4'h7: f = 16'h5695;
        4'h8: f = 16'h5A67;
        4'h9: f = 16'h5E65;
        4'hA: f = 16'h628E;
        4'hB: f = 16'h66E7;
        4'hC: f = 16'h6B72;
        4'hD: f = 16'h702F;
        4'hE: f = 16'h7522;
        default: f = 16'h7A4E;
      endcase
      p = $signed(smp) * $signed({1'b0, f});
      p = (p <<< d[7:4]) >>> 23;
      if (code == `GAIN_MUTE)
        scale = {DW{1'b0}};
      else if (p >= lim)
        scale = {1'b0, {(DW-1){1'b1}}};
      else if (p < -lim)
        scale = {1'b1, {(DW-1){1'b0}}};
      else
        scale = p[DW-1:0];
    end
  endfunction

  assign scaled_o = scale(sample_i, gain_o);

  // Pending gain, timeout counter and update at crossing
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      gain_o <= `IN_GAIN_RESET;
      last_wr <= `IN_GAIN_RESET;
      pending <= `IN_GAIN_RESET;
      busy <= 1'b0;
      cnt <= 11'h000;
      prev_sign <= 1'b0;
    end else begin
      if (step_i)
        prev_sign <= sample_i[DW-1];
      if (wr_i)
        last_wr <= wr_gain_i;
      if (!run_i) begin
        gain_o <= wr_i ? wr_gain_i : (busy ? pending : gain_o);
        busy <= 1'b0;
      end else if (wr_i && force_i) begin
        gain_o <= wr_gain_i;
        busy <= 1'b0;
      end else if (wr_i && wr_gain_i != last_wr) begin
        pending <= wr_gain_i;
        busy <= 1'b1;
        cnt <= 11'h000;
      end else if (busy && step_i) begin
        if (zc || cnt == tmo) begin
          gain_o <= pending;
          busy <= 1'b0;
        end else begin
          cnt <= cnt + 11'h001;
        end
      end
    end
  end
endmodule

// file: verilog/alc_input_digital_volume.v
// Recording-path digital volume with level control and manual mode
`timescale 1ns/1ps
`include "alc_volume_defs.vh"
module alc_input_digital_volume #(
  parameter DW = 24,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Incoming samples
  input wire in_valid_i,
  input wire [DW-1:0] in_left_i,
  input wire [DW-1:0] in_right_i,
  output wire in_ready_o,
  // Outgoing samples
  output reg out_valid_o,
  output reg [DW-1:0] out_left_o,
  output reg [DW-1:0] out_right_o,
  input wire out_ready_i,
  // Mode control
  input wire rec_level_ctl_en_i,
  input wire play_level_ctl_en_i,
  input wire adc_path_filter_sel_i,
  input wire filter_power_up_i,
  input wire serial_ctl_mode_i,
  // Manual gain
  input wire in_gain_write_i,
  input wire [7:0] in_gain_left_i,
  input wire [7:0] in_gain_right_i,
  input wire in_gain_linked_i,
  // Level-control parameters
  input wire [1:0] zc_timeout_sel_i,
  input wire [2:0] recovery_wait_sel_i,
  input wire [7:0] rec_gain_ceiling_i,
  input wire [1:0] limit_threshold_sel_i,
  input wire [1:0] limit_atten_step_sel_i,
  input wire limit_zc_select_i,
  input wire fast_limit_en_i,
  input wire [1:0] recovery_step_sel_i,
  input wire [1:0] fast_recovery_speed_sel_i,
  // Status
  output reg [7:0] alc_current_gain_o,
  output wire alc_current_gain_valid_o,
  output wire manual_mode_o,
  output reg alc_muted_o
);
  // Magnitude of a signed sample
  function [DW-1:0] mag;
    input [DW-1:0] s;
    begin
      if (s[DW-1])
        mag = ~s + 1'b1;
      else
        mag = s;
    end
  endfunction

  wire fifo_valid;
  wire [2*DW-1:0] fifo_data;
  wire pop = fifo_valid && (!out_valid_o || out_ready_i);
  wire [DW-1:0] smp_l = fifo_data[2*DW-1:DW];
  wire [DW-1:0] smp_r = fifo_data[DW-1:0];
  wire [DW-1:0] scaled_l;
  wire [DW-1:0] scaled_r;
  wire [7:0] gain_l;
  wire [7:0] gain_r;

  // Samples wait here while the output side stalls
  sample_fifo #(
    .WIDTH(2*DW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wr_valid_i(in_valid_i),
    .wr_data_i({in_left_i, in_right_i}),
    .wr_ready_o(in_ready_o),
    .rd_valid_o(fifo_valid),
    .rd_data_o(fifo_data),
    .rd_ready_i(pop)
  );

  // Mode decode
  wire any_en = rec_level_ctl_en_i || play_level_ctl_en_i;
  wire alc_run = rec_level_ctl_en_i && filter_power_up_i;
  assign manual_mode_o = !rec_level_ctl_en_i && adc_path_filter_sel_i && filter_power_up_i;
  assign alc_current_gain_valid_o = serial_ctl_mode_i;

  // Parameters latched only while level control is off
  reg [1:0] lk_thr;
  reg [1:0] lk_att;
  reg [2:0] lk_wait;
  reg [7:0] lk_ceil;
  reg [1:0] lk_rstep;
  reg [1:0] lk_fast;
  reg lk_zc;
  reg lk_flim;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      lk_thr <= 2'h0;
      lk_att <= 2'h0;
      lk_wait <= 3'h0;
      lk_ceil <= `IN_GAIN_RESET;
      lk_rstep <= 2'h0;
      lk_fast <= `FAST_SEL_RESET;
      lk_zc <= 1'b0;
      lk_flim <= 1'b0;
    end else if (!any_en) begin
      lk_thr <= limit_threshold_sel_i;
      lk_att <= limit_atten_step_sel_i;
      lk_wait <= recovery_wait_sel_i;
      lk_ceil <= rec_gain_ceiling_i;
      lk_rstep <= recovery_step_sel_i;
      lk_fast <= fast_recovery_speed_sel_i;
      lk_zc <= limit_zc_select_i;
      lk_flim <= fast_limit_en_i;
    end
  end

  // Limiter and reset levels for the threshold selection
  reg [DW-1:0] lvl_det;
  reg [DW-1:0] lvl_rst;
  always @* begin
    case (lk_thr)
      2'h0: begin
        lvl_det = `LVL_M2P5;
        lvl_rst = `LVL_M4P1;
      end
      2'h1: begin
        lvl_det = `LVL_M4P1;
        lvl_rst = `LVL_M6P0;
      end
      2'h2: begin
        lvl_det = `LVL_M6P0;
        lvl_rst = `LVL_M8P5;
      end
      default: begin
        lvl_det = `LVL_M8P5;
        lvl_rst = `LVL_M12;
      end
    endcase
  end

  // Level of the sample just produced
  wire [DW-1:0] mag_l = mag(out_left_o);
  wire [DW-1:0] mag_r = mag(out_right_o);
  wire [DW-1:0] level = (mag_l > mag_r) ? mag_l : mag_r;
  wire over = level >= lvl_det;
  wire in_band = !over && level >= lvl_rst;

  // Attenuation step per selection
  reg [7:0] att_step;
  always @* begin
    case (lk_att)
      2'h1: att_step = 8'h02;
      2'h2: att_step = 8'h02;
      default: att_step = 8'h01;
    endcase
  end

  // Recovery wait, shortened while fast recovery is armed
  reg fast_rec;
  reg [14:0] wait_cnt;
  reg [3:0] fast_shift;
  always @* begin
    case (lk_fast)
      2'h0: fast_shift = 4'h2;
      2'h1: fast_shift = 4'h3;
      default: fast_shift = 4'h4;
    endcase
  end
  wire [14:0] wait_full = `WAIT_BASE_SAMPLES << lk_wait;
  wire [14:0] wait_len = fast_rec ? (wait_full >> fast_shift) : wait_full;
  wire wait_done = wait_cnt >= wait_len - 15'h0001;

  // Next level-control gain
  reg [7:0] alc_gain;
  reg [7:0] next_alc_gain;
  reg [8:0] up;
  reg alc_limit;
  reg alc_recover;
  always @* begin
    next_alc_gain = alc_gain;
    alc_limit = 1'b0;
    alc_recover = 1'b0;
    up = {1'b0, alc_gain} + {7'h00, lk_rstep} + 9'h001;
    if (over) begin
      alc_limit = 1'b1;
      next_alc_gain = (alc_gain > att_step) ? alc_gain - att_step : `GAIN_MIN;
    end else if (!in_band && wait_done && alc_gain < lk_ceil) begin
      alc_recover = 1'b1;
      next_alc_gain = (up > {1'b0, lk_ceil}) ? lk_ceil : up[7:0];
    end
  end

  // Level-control state runs once per output sample
  reg measure;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      alc_gain <= `IN_GAIN_RESET;
      wait_cnt <= 15'h0000;
      fast_rec <= 1'b0;
      measure <= 1'b0;
    end else begin
      measure <= pop;
      if (!alc_run) begin
        alc_gain <= gain_l;
        wait_cnt <= 15'h0000;
        fast_rec <= 1'b0;
      end else if (measure) begin
        alc_gain <= next_alc_gain;
        if (alc_limit) begin
          wait_cnt <= 15'h0000;
          fast_rec <= 1'b1;
        end else if (in_band || alc_recover) begin
          wait_cnt <= 15'h0000;
          if (alc_recover)
            fast_rec <= 1'b0;
        end else if (!wait_done) begin
          wait_cnt <= wait_cnt + 15'h0001;
        end
      end
    end
  end

  // Live gain copied to status while level control runs
  always @(posedge sys_clk_i) begin
    if (reset_i)
      alc_current_gain_o <= `IN_GAIN_RESET;
    else if (alc_run)
      alc_current_gain_o <= gain_l;
  end

  // Gain requests to the two channels
  wire alc_wr = alc_run && measure && (next_alc_gain != alc_gain);
  wire alc_force = alc_limit && (lk_zc || lk_flim);
  wire ch_wr = alc_run ? alc_wr : in_gain_write_i;
  wire [7:0] req_l = alc_run ? next_alc_gain : in_gain_left_i;
  wire [7:0] req_r = alc_run ? next_alc_gain : (in_gain_linked_i ? in_gain_left_i : in_gain_right_i);

  // Independent crossing and timeout per channel
  gain_channel #(
    .DW(DW)
  ) u_left (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .run_i(filter_power_up_i),
    .step_i(pop),
    .sample_i(smp_l),
    .wr_i(ch_wr),
    .wr_gain_i(req_l),
    .force_i(alc_run && alc_force),
    .zc_sel_i(zc_timeout_sel_i),
    .scaled_o(scaled_l),
    .gain_o(gain_l)
  );

  gain_channel #(
    .DW(DW)
  ) u_right (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .run_i(filter_power_up_i),
    .step_i(pop),
    .sample_i(smp_r),
    .wr_i(ch_wr),
    .wr_gain_i(req_r),
    .force_i(alc_run && alc_force),
    .zc_sel_i(zc_timeout_sel_i),
    .scaled_o(scaled_r),
    .gain_o(gain_r)
  );

  // Silence after level control stops until manual mode begins
  reg any_en_d;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      any_en_d <= 1'b0;
      alc_muted_o <= 1'b0;
    end else begin
      any_en_d <= any_en;
      if (manual_mode_o)
        alc_muted_o <= 1'b0;
      else if (any_en_d && !any_en)
        alc_muted_o <= 1'b1;
    end
  end

  // Output register with back-pressure
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      out_valid_o <= 1'b0;
      out_left_o <= {DW{1'b0}};
      out_right_o <= {DW{1'b0}};
    end else begin
      if (pop) begin
        out_valid_o <= 1'b1;
        out_left_o <= alc_muted_o ? {DW{1'b0}} : scaled_l;
        out_right_o <= alc_muted_o ? {DW{1'b0}} : scaled_r;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule

// file: dv/alc_volume_monitor.sv
// Port assertions for the recording digital volume
`timescale 1ns/1ps
module alc_volume_monitor #(
  parameter DW = 24
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Sample outputs
  input wire out_valid_o,
  input wire out_ready_i,
  input wire [DW-1:0] out_left_o,
  input wire [DW-1:0] out_right_o,
  // Mode and parameters
  input wire rec_level_ctl_en_i,
  input wire play_level_ctl_en_i,
  input wire adc_path_filter_sel_i,
  input wire filter_power_up_i,
  input wire serial_ctl_mode_i,
  input wire [7:0] rec_gain_ceiling_i,
  input wire [1:0] recovery_step_sel_i,
  // Status
  input wire [7:0] alc_current_gain_o,
  input wire alc_current_gain_valid_o,
  input wire manual_mode_o,
  input wire alc_muted_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Readback is only trusted in three-wire mode
  a_read_valid: assert property (alc_current_gain_valid_o == serial_ctl_mode_i)
    else $error("gain readback valid flag wrong");
  a_manual_mode: assert property (
    manual_mode_o == (!rec_level_ctl_en_i && adc_path_filter_sel_i && filter_power_up_i))
    else $error("manual mode flag wrong");
  a_ceiling_hold: assert property (rec_level_ctl_en_i && $past(rec_level_ctl_en_i) &&
    alc_current_gain_o > $past(alc_current_gain_o) |-> alc_current_gain_o <= rec_gain_ceiling_i)
    else $error("gain rose above ceiling");
  a_recovery_step: assert property (rec_level_ctl_en_i && $past(rec_level_ctl_en_i) &&
    alc_current_gain_o > $past(alc_current_gain_o) |->
    alc_current_gain_o - $past(alc_current_gain_o) <= {6'h00, recovery_step_sel_i} + 8'h01)
    else $error("recovery step too large");
  a_gain_frozen: assert property (!rec_level_ctl_en_i && !$past(rec_level_ctl_en_i)
    |-> $stable(alc_current_gain_o))
    else $error("current gain moved outside level control");
  // A pair loaded while muted must be silent; a pair already standing may predate the mute
  a_mute_zero: assert property ($past(alc_muted_o) && out_valid_o &&
    (!$past(out_valid_o) || $past(out_ready_i)) |-> out_left_o == {DW{1'b0}} && out_right_o == {DW{1'b0}})
    else $error("muted output not zero");
  a_mute_entry: assert property ($fell(rec_level_ctl_en_i || play_level_ctl_en_i) &&
    !manual_mode_o |-> ##[1:2] alc_muted_o)
    else $error("mute not set after enables cleared");
  a_mute_exit: assert property (alc_muted_o && manual_mode_o |-> ##[1:2] !alc_muted_o)
    else $error("mute not cleared in manual mode");
endmodule

bind alc_input_digital_volume alc_volume_monitor #(.DW(DW)) i_mon (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_left_o(out_left_o), .out_right_o(out_right_o), .rec_level_ctl_en_i(rec_level_ctl_en_i),
  .play_level_ctl_en_i(play_level_ctl_en_i), .adc_path_filter_sel_i(adc_path_filter_sel_i),
  .filter_power_up_i(filter_power_up_i), .serial_ctl_mode_i(serial_ctl_mode_i),
  .rec_gain_ceiling_i(rec_gain_ceiling_i), .recovery_step_sel_i(recovery_step_sel_i),
  .alc_current_gain_o(alc_current_gain_o), .alc_current_gain_valid_o(alc_current_gain_valid_o),
  .manual_mode_o(manual_mode_o), .alc_muted_o(alc_muted_o));

// file: dv/sample_sink_model.sv
// Sink model at the outgoing sample port
`timescale 1ns/1ps
module sample_sink_model (
  // Clock
  input wire sys_clk_i,
  // Sample port
  input wire valid_i,
  input wire [23:0] left_i,
  input wire [23:0] right_i,
  input wire stall_i,
  output wire ready_o,
  // Observed traffic
  output reg [23:0] last_left_o = 24'h00_0000,
  output reg [23:0] last_right_o = 24'h00_0000,
  output reg [31:0] count_o = 32'h0000_0000
);
  // Stall is applied off the rising edge by the bench
  assign ready_o = !stall_i;
  // Capture each accepted pair
  always @(posedge sys_clk_i) begin
    if (valid_i && ready_o) begin
      last_left_o <= left_i;
      last_right_o <= right_i;
      count_o <= count_o + 32'h0000_0001;
    end
  end
endmodule

// file: dv/alc_input_digital_volume_bench.sv
// Self-checking bench for the recording digital volume
`timescale 1ns/1ps
module alc_input_digital_volume_bench;
  logic clk = 1'b0, rst = 1'b1, iv = 1'b0, wr = 1'b0, lk = 1'b0, rec = 1'b0, ply = 1'b0;
  logic sel = 1'b1, pwr = 1'b1, ser = 1'b1, stall = 1'b0;
  logic [23:0] il = 24'h00_0000, ir = 24'h00_0000, el, er;
  logic [7:0] gl = 8'hE1, gr = 8'hE1, ceil = 8'hE1, n;
  logic [1:0] zs = 2'h0, st = 2'h0;
  logic [2:0] ws = 3'h0;
  wire rdy, ov, ordy, gv, mm, mu;
  wire [23:0] ol, orr, sl, sr;
  wire [7:0] cg;
  wire [31:0] cnt;
  logic [31:0] c0;
  int fail_count = 0, n_tests = 0;
  integer seed = 32'h878016c6;
  // Clock
  always #10 clk = ~clk;
  alc_input_digital_volume i_dut (.sys_clk_i(clk), .reset_i(rst), .in_valid_i(iv), .in_left_i(il),
    .in_right_i(ir), .in_ready_o(rdy), .out_valid_o(ov), .out_left_o(ol), .out_right_o(orr),
    .out_ready_i(ordy), .rec_level_ctl_en_i(rec), .play_level_ctl_en_i(ply),
    .adc_path_filter_sel_i(sel), .filter_power_up_i(pwr), .serial_ctl_mode_i(ser),
    .in_gain_write_i(wr), .in_gain_left_i(gl), .in_gain_right_i(gr), .in_gain_linked_i(lk),
    .zc_timeout_sel_i(zs), .recovery_wait_sel_i(ws), .rec_gain_ceiling_i(ceil),
    .limit_threshold_sel_i(2'h1), .limit_atten_step_sel_i(2'h0), .limit_zc_select_i(1'b0),
    .fast_limit_en_i(1'b1), .recovery_step_sel_i(st), .fast_recovery_speed_sel_i(2'h0),
    .alc_current_gain_o(cg), .alc_current_gain_valid_o(gv), .manual_mode_o(mm), .alc_muted_o(mu));
  sample_sink_model i_sink (.sys_clk_i(clk), .valid_i(ov), .left_i(ol), .right_i(orr),
    .stall_i(stall), .ready_o(ordy), .last_left_o(sl), .last_right_o(sr), .count_o(cnt));
  // Comparisons
  task automatic chk_s(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    chk_s({16'h0000, got}, {16'h0000, exp});
  endtask
  task test_done;
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Small random samples, positive or of random sign
  function automatic logic [23:0] pos();
    pos = {14'h0000, 10'($random(seed))} | 24'h00_0001;
  endfunction
  function automatic logic [23:0] sgn();
    logic [23:0] v;
    v = pos();
    sgn = seed[0] ? -v : v;
  endfunction
  // Unity for code 91H, exact zero for code 00H
  function automatic logic [23:0] expv(input logic [23:0] s, input logic [7:0] g);
    expv = (g == 8'h00) ? 24'h00_0000 : s;
  endfunction
  // Stimulus helpers, entered at a falling edge
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    il = l;
    ir = r;
    iv = 1'b1;
    for (int k = 0; k < 50 && !rdy; k++) @(negedge clk);
    @(negedge clk);
    iv = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic gw(input logic [7:0] l, input logic [7:0] r);
    gl = l;
    gr = r;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic run(input int cnt_n);
    repeat (cnt_n) send(pos(), pos());
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_b(cg, 8'hE1);
    chk_b({6'h00, rdy, ov}, 8'h02);
    gw(8'h91, 8'h91);
    run(120);
    chk_b({7'h00, sl !== il}, 8'h01);
    run(15);
    chk_s(sl, il);
    chk_s(sr, ir);
    $display("manual timeout done");
    stall = 1'b1;
    n = 8'h00;
    il = pos();
    ir = pos();
    iv = 1'b1;
    c0 = cnt;
    while (rdy && n < 8'h08) begin
      @(negedge clk);
      n++;
      el = il;
      er = ir;
      il = pos();
      ir = pos();
    end
    iv = 1'b0;
    chk_b(n, 8'h05);
    stall = 1'b0;
    repeat (12) @(negedge clk);
    chk_b(8'(cnt - c0), 8'h05);
    chk_s(sl, el);
    chk_s(sr, er);
    $display("buffer done");
    gw(8'h00, 8'h00);
    send(-pos(), pos());
    send(-pos(), pos());
    chk_s(sl, 24'h00_0000);
    chk_s(sr, ir);
    run(130);
    lk = 1'b1;
    gw(8'h91, 8'h00);
    send(-pos(), -pos());
    send(-pos(), -pos());
    chk_s(sl, il);
    chk_s(sr, ir);
    lk = 1'b0;
    $display("crossing and link done");
    run(130);
    gw(8'h00, 8'h00);
    repeat (3) begin
      run(50);
      gw(8'h00, 8'h00);
    end
    chk_s(sl, expv(il, 8'h00));
    gw(8'h91, 8'h91);
    run(100);
    gw(8'h40, 8'h40);
    run(100);
    gw(8'h91, 8'h91);
    run(100);
    chk_s(sl, expv(il, 8'h00));
    run(40);
    chk_s(sl, expv(il, 8'h91));
    $display("rewrite done");
    ceil = 8'h99;
    st = 2'h3;
    ws = 3'h0;
    sel = 1'b0;
    // Parameters settle one cycle before the enable so they are latched
    @(negedge clk);
    rec = 1'b1;
    repeat (600) send(sgn(), sgn());
    chk_b(cg, 8'h99);
    chk_b({7'h00, mm}, 8'h00);
    rec = 1'b0;
    send(pos(), pos());
    chk_s(sl, 24'h00_0000);
    chk_b({7'h00, mu}, 8'h01);
    sel = 1'b1;
    send(pos(), pos());
    chk_b({6'h00, mm, mu}, 8'h02);
    ser = 1'b0;
    @(negedge clk);
    chk_b({7'h00, gv}, 8'h00);
    ser = 1'b1;
    // Playback enable alone also silences the stage when it clears
    sel = 1'b0;
    ply = 1'b1;
    @(negedge clk);
    chk_b({7'h00, mm}, 8'h00);
    ply = 1'b0;
    send(pos(), pos());
    chk_s(sr, 24'h00_0000);
    sel = 1'b1;
    send(pos(), pos());
    chk_b({6'h00, mm, mu}, 8'h02);
    $display("level control done");
    pwr = 1'b0;
    gw(8'h00, 8'h00);
    pwr = 1'b1;
    send(pos(), pos());
    send(pos(), pos());
    chk_s(sl, 24'h00_0000);
    $display("power-up hold done");
    test_done();
  end
endmodule
